// file: core/uniform_adc_sampler.sv
// Purpose: single and paced burst acquisition from a serial converter
// Assumes: converter answers each frame on its data pin; one clock
// Notes: burst samples appear one at a time in the result register
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module uniform_adc_sampler
    import adc_sampler_pkg::*;
#(
    parameter int ACQ_LEN = ACQ_CYCLES
)(
    input wire logic clk, // System clock
    input wire logic resetn, // Async reset, low active
    input wire logic [4:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    output logic irq, // Level interrupt
    output logic conv_csn, // Converter select, low active
    output logic conv_sclk, // Converter serial clock
    output logic conv_din, // Command to converter
    input wire logic conv_dout, // Data from converter
    output logic hold_interrupts // Ask controller to hold off
);
    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        SHIFT = 4'b0010,
        SETTLE = 4'b0100,
        WAIT_PACE = 4'b1000
    } state_t;

    // Sign-aware formatting of a raw frame
    function automatic logic [15:0] format_result(input logic [11:0] raw, input logic wide, input logic uni);
        logic [11:0] v;
        v = wide ? raw : {raw[11:2], 2'b00};
        format_result = uni ? {4'h0, v} : {{4{~v[11]}}, ~v[11], v[10:0]};
    endfunction : format_result

    state_t state;
    logic [31:0] ctrl;
    logic [15:0] divider;
    logic [15:0] sample_count;
    logic [15:0] taken;
    logic [15:0] result;
    logic [3:0] ev;
    logic [3:0] mask;
    logic burst_ok;
    logic [15:0] shreg;
    logic [4:0] bitn;
    logic [3:0] sdiv;
    logic [31:0] acq_cnt;
    logic [23:0] pace_cnt;
    logic pace_tick;
    logic d1, d2, d3;
    logic frame_err;
    logic [3:0] next_ev;

    // Pin sampling: third stage is shifted in; second and third stage disagreeing marks a frame error
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            d1 <= 1'b0;
            d2 <= 1'b0;
            d3 <= 1'b0;
        end
        else
        begin
            d1 <= conv_dout;
            d2 <= d1;
            d3 <= d2;
        end
    end
    wire din_ok = (d2 == d3);

    // Bus decode, single cycle wait; writes land on the answer edge, not before
    wire ack = ~waitrequest; // Answer cycle
    wire req = (read | write) & ~ack;
    wire wr_ctrl = write & ack & (address == OFF_CTRL);
    wire wr_div = write & ack & (address == OFF_DIV);
    wire wr_cnt = write & ack & (address == OFF_COUNT);
    wire wr_mask = write & ack & (address == OFF_MASK);
    wire rd_irq = read & ~ack & (address == OFF_IRQ);
    wire busy = (state != IDLE);
    wire [15:0] div_eff = (divider < DIV_MIN) ? DIV_MIN : divider;
    wire [23:0] interval = 24'(div_eff) * 24'(INTERVAL_MULT);
    wire start_single = wr_ctrl & writedata[CTRL_START_BIT] & ~busy;
    wire start_burst = wr_ctrl & writedata[CTRL_BURST_BIT] & ~busy & (sample_count != 16'h0000);
    wire in_burst = ctrl[CTRL_BURST_BIT];
    wire frame_end = (state == SHIFT) && (bitn == 5'(FRAME_BITS)) && (sdiv == 4'h0);
    wire acq_end = (state == SETTLE) && (acq_cnt == 32'h0);
    wire missed = in_burst & pace_tick & (state == SHIFT || state == SETTLE);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            waitrequest <= ~req;
            if (req)
            begin
                case (address)
                    OFF_CTRL: readdata <= ctrl;
                    OFF_DIV: readdata <= {16'h0000, divider};
                    OFF_COUNT: readdata <= {16'h0000, sample_count};
                    OFF_RESULT: readdata <= {16'h0000, result};
                    OFF_STATUS: readdata <= {15'h0000, burst_ok, taken};
                    OFF_IRQ: readdata <= {28'h0000000, ev};
                    OFF_MASK: readdata <= {28'h0000000, mask};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Configuration registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= CTRL_RESET;
            divider <= DIV_RESET;
            sample_count <= 16'h0000;
            mask <= 4'h0;
        end
        else
        begin
            if (wr_ctrl && !busy)
                ctrl <= writedata & 32'h0000_061F;
            else if (busy && state == IDLE)
                ctrl <= ctrl;
            if (wr_div)
                divider <= writedata[15:0];
            if (wr_cnt)
                sample_count <= writedata[15:0];
            if (wr_mask)
                mask <= writedata[3:0];
        end
    end

    // Pacing timer, reloads every interval during a burst
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pace_cnt <= 24'h0;
            pace_tick <= 1'b0;
        end
        else
        begin
            pace_tick <= 1'b0;
            // First period one short: the tick flop adds a cycle before the frame
            if (start_burst)
                pace_cnt <= interval - 24'h2;
            else if (!in_burst || state == IDLE)
                pace_cnt <= interval - 24'h1;
            else if (pace_cnt == 24'h0)
            begin
                pace_cnt <= interval - 24'h1;
                pace_tick <= 1'b1;
            end
            else
                pace_cnt <= pace_cnt - 24'h1;
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= IDLE;
            shreg <= 16'h0;
            bitn <= 5'h0;
            sdiv <= 4'h0;
            acq_cnt <= 32'h0;
            conv_csn <= 1'b1;
            conv_sclk <= 1'b0;
            conv_din <= 1'b0;
            taken <= 16'h0;
            result <= 16'h0;
            burst_ok <= 1'b1;
            frame_err <= 1'b0;
            hold_interrupts <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    if (start_single || start_burst)
                    begin
                        // Command word: start, polarity, channel
                        shreg <= {1'b1, writedata[CTRL_POL_BIT], writedata[2:0], 11'h0};
                        state <= SHIFT;
                        conv_csn <= 1'b0;
                        conv_din <= 1'b1; // Start bit leads the command
                        bitn <= 5'h0;
                        sdiv <= SCLK_HALF;
                        acq_cnt <= 32'(ACQ_LEN);
                        frame_err <= 1'b0;
                        taken <= 16'h0;
                        burst_ok <= 1'b1;
                        // Controller should hold off others unless option set
                        hold_interrupts <= ~writedata[CTRL_KEEP_INT_BIT];
                    end
                end
                SHIFT:
                begin
                    if (acq_cnt != 32'h0)
                        acq_cnt <= acq_cnt - 32'h1;
                    if (frame_end)
                    begin
                        conv_csn <= 1'b1;
                        state <= SETTLE;
                    end
                    else if (sdiv == 4'h0)
                    begin
                        sdiv <= SCLK_HALF;
                        conv_sclk <= ~conv_sclk;
                        if (conv_sclk)
                        begin
                            conv_din <= shreg[15];
                            bitn <= bitn + 5'h1;
                        end
                        else
                        begin
                            shreg <= {shreg[14:0], d3};
                            frame_err <= frame_err | ~din_ok;
                        end
                    end
                    else
                        sdiv <= sdiv - 4'h1;
                end
                SETTLE:
                begin
                    conv_sclk <= 1'b0;
                    if (acq_cnt != 32'h0)
                        acq_cnt <= acq_cnt - 32'h1;
                    if (acq_end)
                    begin
                        result <= frame_err ? ERROR_CODE : format_result(shreg[11:0], ctrl[CTRL_WIDE_BIT] & ~in_burst,
                            ctrl[CTRL_POL_BIT]);
                        taken <= taken + 16'h1;
                        if (in_burst && (taken + 16'h1) < sample_count)
                            state <= WAIT_PACE;
                        else
                        begin
                            state <= IDLE;
                            hold_interrupts <= 1'b0;
                        end
                    end
                    if (missed)
                        burst_ok <= 1'b0;
                end
                WAIT_PACE:
                begin
                    if (pace_tick)
                    begin
                        shreg <= {1'b1, ctrl[CTRL_POL_BIT], ctrl[2:0], 11'h0};
                        state <= SHIFT;
                        conv_csn <= 1'b0;
                        conv_din <= 1'b1;
                        bitn <= 5'h0;
                        sdiv <= SCLK_HALF;
                        acq_cnt <= 32'(ACQ_LEN);
                        frame_err <= 1'b0;
                    end
                end
                default: state <= IDLE;
            endcase
            if (missed && state == SHIFT)
                burst_ok <= 1'b0;
        end
    end

    // Sticky events; a read of the event register clears, set wins
    always_comb
    begin
        next_ev = rd_irq ? 4'h0 : ev;
        next_ev[EV_DONE] = next_ev[EV_DONE] | (acq_end & (!in_burst || (taken + 16'h1) >= sample_count));
        next_ev[EV_SAMPLE] = next_ev[EV_SAMPLE] | acq_end;
        next_ev[EV_MISS] = next_ev[EV_MISS] | missed;
        next_ev[EV_ERROR] = next_ev[EV_ERROR] | (acq_end & frame_err);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ev <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            ev <= next_ev;
            irq <= |(next_ev & mask);
        end
    end

    // Result never outside the documented signed or unsigned span
    result_span_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(result) && ctrl[CTRL_POL_BIT] |-> result == ERROR_CODE || result[15:12] == 4'h0)
        else $error("unipolar result out of span");
    narrow_low_a: assert property (@(posedge clk) disable iff (!resetn)
        acq_end && !frame_err && !ctrl[CTRL_WIDE_BIT] |=> result[1:0] == 2'b00)
        else $error("ten-bit result low bits not zero");
    error_code_a: assert property (@(posedge clk) disable iff (!resetn)
        acq_end && frame_err |=> result == ERROR_CODE)
        else $error("error code not returned");
    miss_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        missed |=> !burst_ok)
        else $error("missed sample not flagged");
    count_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        state != IDLE && in_burst |-> taken <= sample_count)
        else $error("burst count overrun");
    divider_min_a: assert property (@(posedge clk) disable iff (!resetn)
        interval >= 24'(DIV_MIN) * 24'(INTERVAL_MULT))
        else $error("pacing interval below minimum");
    bipolar_sign_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(result) && !ctrl[CTRL_POL_BIT] && result != ERROR_CODE |-> result[15:12] == {4{result[11]}})
        else $error("bipolar result not sign extended");
    chan_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
        start_single |=> shreg[13:11] == $past(writedata[2:0]))
        else $error("channel index not loaded");
endmodule : uniform_adc_sampler

// file: core/adc_sampler_pkg.sv
// Purpose: constants for the uniform converter sampler
// Assumes: 125 MHz system clock, Avalon-MM register access
// Notes: all offsets are byte addresses of 32-bit words
package adc_sampler_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ACQ_TIME_US = 120;
    localparam int ACQ_CYCLES = ACQ_TIME_US * CLK_MHZ;
    localparam logic [15:0] DIV_MIN = 16'h0024;
    localparam logic [7:0] INTERVAL_MULT = 8'h14;
    localparam logic [15:0] ERROR_CODE = 16'h8000;
    localparam logic [3:0] SCLK_HALF = 4'h8;
    // Register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_DIV = 5'h04;
    localparam logic [4:0] OFF_COUNT = 5'h08;
    localparam logic [4:0] OFF_RESULT = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ = 5'h14;
    localparam logic [4:0] OFF_MASK = 5'h18;
    // Control fields
    localparam int CTRL_CHAN_LSB = 0;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_WIDE_BIT = 4;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_BURST_BIT = 9;
    localparam int CTRL_KEEP_INT_BIT = 10;
    // Event bits
    localparam int EV_DONE = 0;
    localparam int EV_SAMPLE = 1;
    localparam int EV_MISS = 2;
    localparam int EV_ERROR = 3;
    localparam int FRAME_BITS = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] DIV_RESET = 16'h0024;
endpackage : adc_sampler_pkg

// file: test/conv_model.sv
// Purpose: serial converter seen from the sampler's pins
// Assumes: bits leave on falling serial clock, most significant first
// Notes: released data line toggles every cycle so stale bits never match
`timescale 1ns/1ps
module conv_model (
    input wire logic clk, // System clock
    input wire logic conv_csn, // Select, low active
    input wire logic conv_sclk, // Serial clock
    input wire logic conv_din, // Command from sampler
    input wire logic [15:0] word, // Frame to send back
    input wire logic noisy, // Shake the line in frame
    output logic conv_dout, // Data to sampler
    output logic [15:0] cmd // Command bits seen
);
    logic [15:0] shift = 16'h0000;
    logic prev_sclk = 1'b0;
    logic prev_csn = 1'b1;
    initial conv_dout = 1'b0;
    initial cmd = 16'h0000;
    // Command bits taken just after each rising serial clock
    always @(posedge clk)
    begin
        if (!conv_csn && !prev_sclk && conv_sclk)
            cmd <= {cmd[14:0], conv_din};
    end
    // Clean frame: first bit at select, then change only after a falling clock, so the line is steady at the rising one
    always @(posedge clk)
    begin
        prev_sclk <= conv_sclk;
        prev_csn <= conv_csn;
        if (conv_csn)
            conv_dout <= ~conv_dout; // Not selected: no valid level
        else if (noisy)
            conv_dout <= ~conv_dout;
        else if (prev_csn)
        begin
            conv_dout <= word[15];
            shift <= {word[14:0], 1'b0};
        end
        else if (prev_sclk && !conv_sclk)
        begin
            conv_dout <= shift[15];
            shift <= {shift[14:0], 1'b0};
        end
    end
endmodule : conv_model

// file: test/uniform_adc_sampler_test.sv
// Purpose: register-level tests of single and paced acquisitions
// Assumes: one wait state per access, short acquisition parameter
// Notes: interval figures come from twenty times the divider floor
`timescale 1ns/1ps
module uniform_adc_sampler_test;
    import adc_sampler_pkg::*;
    localparam int ACQ = 400;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic conv_csn;
    logic conv_sclk;
    logic conv_din;
    logic conv_dout;
    logic hold_interrupts;
    logic [15:0] word = 16'h0000;
    logic [15:0] cmd;
    logic noisy = 1'b0;
    logic [31:0] rd;
    logic [31:0] ctrl;
    logic [15:0] exp;
    logic [2:0] c;
    int n;
    int cycles = 0;
    int miscompares = 0;
    int tests_run = 0;
    int csn_fall [$];
    logic [15:0] words [9] = '{16'h0000, 16'h0FFF, 16'hF6BF, 16'h0FFF, 16'h0FFF, 16'h0803, 16'h0FFF,
        16'h0001, 16'h0123};
    logic [4:0] zero_regs [4] = '{OFF_CTRL, OFF_MASK, OFF_IRQ, 5'h1C};

    uniform_adc_sampler #(.ACQ_LEN(ACQ)) dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .conv_csn(conv_csn), .conv_sclk(conv_sclk), .conv_din(conv_din), .conv_dout(conv_dout),
        .hold_interrupts(hold_interrupts));
    conv_model far_end (.clk(clk), .conv_csn(conv_csn), .conv_sclk(conv_sclk), .conv_din(conv_din),
        .word(word), .noisy(noisy), .conv_dout(conv_dout), .cmd(cmd));

    // Clock, cycle count and hang guard
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    // Frame start times, for spacing of paced samples
    always @(negedge conv_csn)
        csn_fall.push_back(cycles);

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // One access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 40);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        check({31'h0, k < 40}, 32'h1);
        @(posedge clk);
    endtask : bus

    task automatic wait_irq(input int lim, output int k);
        k = 0;
        while (irq !== 1'b1 && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        check({31'h0, irq}, 32'h1);
    endtask : wait_irq

    // Reference formatting: 10-bit drops two raw bits, bipolar flips offset binary
    function automatic logic [15:0] fmt(input logic [15:0] w, input logic uni, input logic wide);
        logic [11:0] raw;
        raw = wide ? w[11:0] : {w[11:2], 2'b00};
        if (!uni)
            raw[11] = ~raw[11];
        return uni ? {4'h0, raw} : {{4{raw[11]}}, raw};
    endfunction : fmt

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(1'b1, 5'h1C, 32'hFFFF_FFFF, rd);
        bus(1'b0, OFF_DIV, 32'h0, rd);
        check(rd, {16'h0, DIV_RESET});
        foreach (zero_regs[j])
        begin
            bus(1'b0, zero_regs[j], 32'h0, rd);
            check(rd, 32'h0);
        end
        $display("reset values test done");
        // Every channel, both polarities, both widths, then a failed frame
        bus(1'b1, OFF_MASK, 32'h9, rd);
        for (int i = 0; i < 9; i++)
        begin
            c = 3'(i);
            word <= words[i];
            noisy <= (i == 8);
            ctrl = {21'h0, i == 7, 1'b0, 1'b1, 3'h0, c[2], c[1], c};
            exp = (i == 8) ? ERROR_CODE : fmt(words[i], c[1], c[2]);
            bus(1'b1, OFF_CTRL, ctrl, rd);
            check({31'h0, hold_interrupts}, {31'h0, i != 7});
            wait_irq(ACQ + 60, n);
            check({31'h0, n > ACQ - 12}, 32'h1);
            check({31'h0, hold_interrupts}, 32'h0);
            check({16'h0, cmd}, {16'h0, 1'b1, c[1], c, 11'h0});
            bus(1'b0, OFF_IRQ, 32'h0, rd);
            check({31'h0, rd[i == 8 ? EV_ERROR : EV_DONE]}, 32'h1);
            bus(1'b0, OFF_RESULT, 32'h0, rd);
            check({16'h0, rd[15:0]}, {16'h0, exp});
        end
        $display("single acquisition test done");
        // Paced burst: divider below floor, interrupts masked meanwhile
        noisy <= 1'b0;
        word <= 16'h0ABC;
        bus(1'b1, OFF_MASK, 32'h0, rd);
        bus(1'b1, OFF_DIV, 32'd10, rd);
        bus(1'b1, OFF_COUNT, 32'd3, rd);
        csn_fall.delete();
        bus(1'b1, OFF_CTRL, 32'h0000_0205, rd);
        check({31'h0, hold_interrupts}, 32'h1);
        repeat (3 * 720 + ACQ + 800) @(posedge clk);
        check({31'h0, hold_interrupts}, 32'h0);
        check(csn_fall.size(), 3);
        check(csn_fall[1] - csn_fall[0], 20 * 36);
        check(csn_fall[2] - csn_fall[1], 20 * 36);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_STATUS, 32'h0, rd);
        check(rd, 32'h0001_0003);
        bus(1'b0, OFF_RESULT, 32'h0, rd);
        check({16'h0, rd[15:0]}, {16'h0, fmt(16'h0ABC, 1'b0, 1'b0)});
        bus(1'b1, OFF_MASK, 32'h2, rd);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, OFF_IRQ, 32'h0, rd);
        check({30'h0, rd[2:1]}, 32'h1);
        bus(1'b0, OFF_IRQ, 32'h0, rd);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("burst test done");
        report_and_stop();
    end
endmodule : uniform_adc_sampler_test
